// ### include/asc_consts.vh
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// register byte offsets
`define ASC_OFF_CTRL_ONE 8'h00
`define ASC_OFF_CTRL_TWO 8'h04
`define ASC_OFF_COMMON 8'h08
`define ASC_OFF_SMP_HI 8'h0C
`define ASC_OFF_SMP_LO 8'h10
`define ASC_OFF_REG_LEN 8'h14
`define ASC_OFF_REG_SLOT_LO 8'h18
`define ASC_OFF_REG_SLOT_HI 8'h1C
`define ASC_OFF_INJ_SEQ 8'h20
`define ASC_OFF_STATUS 8'h24
`define ASC_OFF_REG_RES 8'h40
`define ASC_OFF_INJ_RES 8'h80

// control one fields
`define ASC_BIT_RES 24
`define ASC_BIT_DISC_CNT 13
`define ASC_BIT_INJ_DISC 12
`define ASC_BIT_REG_DISC 11
`define ASC_BIT_AUTO_INJ 10
`define ASC_BIT_SCAN 8
`define ASC_BIT_INJ_DONE_IE 7
`define ASC_BIT_DONE_IE 5
// control two fields
`define ASC_BIT_END_SEL 10
`define ASC_BIT_ALIGN 11
`define ASC_BIT_REPEAT 1
`define ASC_BIT_POWER 0
// common field
`define ASC_BIT_PRESCALE 16
// injected sequence field
`define ASC_BIT_INJ_LEN 20
// status fields
`define ASC_BIT_DONE_FLAG 0
`define ASC_BIT_INJ_FLAG 1
`define ASC_BIT_ACTIVE 2

// reset values
`define ASC_RST_CTRL_ONE 32'h0000_0000
`define ASC_RST_CTRL_TWO 32'h0000_0001
`define ASC_RST_ZERO 32'h0000_0000

// conversion length in converter clock cycles per resolution
`define ASC_CONV_LEN_12 10'h00F
`define ASC_CONV_LEN_10 10'h00D
`define ASC_CONV_LEN_8 10'h00B
`define ASC_CONV_LEN_6 10'h009

// sample times in converter clock cycles
`define ASC_SMP_0 10'h003
`define ASC_SMP_1 10'h00F
`define ASC_SMP_2 10'h01C
`define ASC_SMP_3 10'h038
`define ASC_SMP_4 10'h054
`define ASC_SMP_5 10'h070
`define ASC_SMP_6 10'h090
`define ASC_SMP_7 10'h1E0

`endif

// ### hdl/asc_conv_timer.v
`timescale 1ns/100ps
`include "asc_consts.vh"

module asc_conv_timer (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // configuration
    input wire [1:0] prescaleSel,
    // request
    input wire start,
    input wire [9:0] cycles,
    // status
    output reg busy_q,
    output reg done_q
);

    reg [3:0] divCnt_q;
    reg [9:0] cnt_q;
    reg [3:0] divMax;
    wire tick;

    // divide by 2, 4, 8 or 16
    always @* begin
        case (prescaleSel)
            2'h0: divMax = 4'h1;
            2'h1: divMax = 4'h3;
            2'h2: divMax = 4'h7;
            default: divMax = 4'hF;
        endcase
    end

    assign tick = (divCnt_q == divMax);

    // divider restarts with each conversion so its length is exact
    always @(posedge clk) begin
        if (!reset_n) begin
            divCnt_q <= 4'h0;
            cnt_q <= 10'h000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                divCnt_q <= 4'h0;
                cnt_q <= cycles;
                busy_q <= 1'b1;
            end else begin
                divCnt_q <= tick ? 4'h0 : divCnt_q + 4'h1;
                if (busy_q && tick) begin
                    cnt_q <= cnt_q - 10'h001;
                    if (cnt_q == 10'h001) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// ### hdl/asc_sequencer.v
`timescale 1ns/100ps
`include "asc_consts.vh"

// Overview of operation
// - converter clock is the peripheral clock divided by 2, 4, 8 or 16.
// - resolution 12/10/8/6 bits takes 15/13/11/9 converter cycles.
// - a separate 16-bit result is kept for each of 16 regular slots.
// - all four injected holding results are presented together.
// - result outputs carry only as many entries as the sequence length.
// - regular discontinuous mode converts count field plus one per trigger, capped by the rest of the sequence.
// - injected discontinuous enable selects injected discontinuous operation.
// - regular discontinuous enable selects regular discontinuous operation.
// - auto-injection starts the injected group after the regular group ends.
// - scan mode runs successive conversions through the sequence per trigger.
// - with scan and both discontinuous bits clear, one channel per trigger.
// - end flag select picks per-group or per-regular-conversion done flag; injected always per group.
// - each input has a 3-bit sample time; internal channel fields unused.
// - up to 16 regular and 4 injected slots, each selecting an input.
// - two dedicated trigger inputs start regular and injected groups.
// - activity output is high while a conversion runs.
// - done pulse output for either group, separate injected end pulse output.
// - lengths are field plus one; injected slots end at the fourth.
// - after the last element the sequence wraps and awaits a trigger.
// - slot field low four bits select analog input 0 to 15.
// - done flag on either group, injected flag on injected; pulses gated.
module asc_sequencer (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // triggers and samples
    input wire regularTrigger,
    input wire injectedTrigger,
    input wire [191:0] analogInput,
    // results
    output reg [255:0] regularResult,
    output reg [63:0] injectedResult,
    // events
    output reg donePulseOut,
    output reg injectedDonePulseOut,
    output reg converterActive
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg [31:0] ctrlOne_q;
    reg [31:0] ctrlTwo_q;
    reg [31:0] common_q;
    reg [31:0] smpHi_q;
    reg [31:0] smpLo_q;
    reg [3:0] regLen_q;
    reg [31:0] regSlotLo_q;
    reg [31:0] regSlotHi_q;
    reg [31:0] injSeq_q;
    reg state_q;
    reg curInj_q;
    reg [3:0] curCh_q;
    reg [3:0] regIdx_q;
    reg [1:0] injIdx_q;
    reg [4:0] regLeft_q;
    reg [2:0] injLeft_q;
    reg autoStart_q;
    reg doneFlag_q;
    reg injFlag_q;
    reg [31:0] rdMux;
    reg rdHit;
    reg [9:0] smpCycles;
    reg [9:0] convLen;

    wire [1:0] resSel = ctrlOne_q[`ASC_BIT_RES +: 2];
    wire [2:0] discCnt = ctrlOne_q[`ASC_BIT_DISC_CNT +: 3];
    wire injDisc = ctrlOne_q[`ASC_BIT_INJ_DISC];
    wire regDisc = ctrlOne_q[`ASC_BIT_REG_DISC];
    wire autoInj = ctrlOne_q[`ASC_BIT_AUTO_INJ];
    wire scanEn = ctrlOne_q[`ASC_BIT_SCAN];
    wire injDoneIe = ctrlOne_q[`ASC_BIT_INJ_DONE_IE];
    wire doneIe = ctrlOne_q[`ASC_BIT_DONE_IE];
    wire endSel = ctrlTwo_q[`ASC_BIT_END_SEL];
    wire [1:0] prescaleSel = common_q[`ASC_BIT_PRESCALE +: 2];
    wire [1:0] injLen = injSeq_q[`ASC_BIT_INJ_LEN +: 2];
    wire [63:0] regSlots = {regSlotHi_q, regSlotLo_q};
    wire [47:0] smpAll = {smpHi_q[17:0], smpLo_q[29:0]};

    // no scan and no discontinuous bit means single mode
    wire singleMode = !scanEn && !regDisc && !injDisc;

    wire apbSetup = psel && !penable;
    wire apbWrite = psel && penable && pready && pwrite;

    wire timerBusy;
    wire timerDone;

    wire [4:0] regRemain = {1'b0, regLen_q} - {1'b0, regIdx_q} + 5'h01;
    wire [2:0] injRemain = {1'b0, injLen} - {1'b0, injIdx_q} + 3'h1;
    wire [4:0] discontinuous_count = {2'b00, discCnt} + 5'h01;

    // count plus one when enabled, capped by the rest
    // scan runs to the end of the sequence
    wire [4:0] regBurst = regDisc ? ((discontinuous_count < regRemain) ? discontinuous_count : regRemain) :
        (scanEn ? regRemain : 5'h01);
    // injected discontinuous converts one element per trigger
    wire [2:0] injBurst = (injDisc || !scanEn) ? 3'h1 : injRemain;

    // injected elements end at the fourth slot
    wire [1:0] injSlot = 2'h3 - injLen + injIdx_q;
    // slot field selects input 0 to 15
    wire [3:0] injCh = injSeq_q[4 * injSlot +: 4];
    wire [3:0] regCh = regSlots[4 * regIdx_q +: 4];
    // injected work pre-empts the regular burst between conversions
    wire startInj = (state_q == ST_IDLE) && !timerBusy && (injLeft_q != 3'h0);
    wire startReg = (state_q == ST_IDLE) && !timerBusy && (injLeft_q == 3'h0) &&
        (regLeft_q != 5'h00);
    wire startConv = startInj || startReg;
    wire [3:0] nextCh = startInj ? injCh : regCh;

    wire regEnd = timerDone && !curInj_q && (regIdx_q == regLen_q);
    wire injEnd = timerDone && curInj_q && (injIdx_q == injLen);
    // per regular conversion when selected or in single mode; injected sets it only at the group end
    wire setDone = (timerDone && !curInj_q && (endSel || singleMode)) || regEnd || injEnd;
    wire setInj = injEnd;

    // resolution drives the right shift and the length
    wire [11:0] rawSample = analogInput[12 * curCh_q +: 12];
    wire [15:0] convResult = {4'h0, rawSample >> {resSel, 1'b0}};

    always @* begin
        case (smpAll[3 * nextCh +: 3])
            3'h0: smpCycles = `ASC_SMP_0;
            3'h1: smpCycles = `ASC_SMP_1;
            3'h2: smpCycles = `ASC_SMP_2;
            3'h3: smpCycles = `ASC_SMP_3;
            3'h4: smpCycles = `ASC_SMP_4;
            3'h5: smpCycles = `ASC_SMP_5;
            3'h6: smpCycles = `ASC_SMP_6;
            default: smpCycles = `ASC_SMP_7;
        endcase
    end

    always @* begin
        case (resSel)
            2'h0: convLen = `ASC_CONV_LEN_12;
            2'h1: convLen = `ASC_CONV_LEN_10;
            2'h2: convLen = `ASC_CONV_LEN_8;
            default: convLen = `ASC_CONV_LEN_6;
        endcase
    end

    asc_conv_timer timer (
        .clk(clk),
        .reset_n(reset_n),
        .prescaleSel(prescaleSel),
        .start(startConv),
        .cycles(smpCycles + convLen),
        .busy_q(timerBusy),
        .done_q(timerDone)
    );

    // register reads
    always @* begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        if (paddr == `ASC_OFF_CTRL_ONE) begin
            rdMux = ctrlOne_q;
        end else if (paddr == `ASC_OFF_CTRL_TWO) begin
            rdMux = ctrlTwo_q;
        end else if (paddr == `ASC_OFF_COMMON) begin
            rdMux = common_q;
        end else if (paddr == `ASC_OFF_SMP_HI) begin
            rdMux = smpHi_q;
        end else if (paddr == `ASC_OFF_SMP_LO) begin
            rdMux = smpLo_q;
        end else if (paddr == `ASC_OFF_REG_LEN) begin
            rdMux = {28'h000_0000, regLen_q};
        end else if (paddr == `ASC_OFF_REG_SLOT_LO) begin
            rdMux = regSlotLo_q;
        end else if (paddr == `ASC_OFF_REG_SLOT_HI) begin
            rdMux = regSlotHi_q;
        end else if (paddr == `ASC_OFF_INJ_SEQ) begin
            rdMux = injSeq_q;
        end else if (paddr == `ASC_OFF_STATUS) begin
            rdMux = {22'h00_0000, injIdx_q, regIdx_q, 1'b0, state_q, injFlag_q, doneFlag_q};
        end else if (paddr[7:6] == 2'h1 && paddr[1:0] == 2'h0) begin
            rdMux = {16'h0000, regularResult[16 * paddr[5:2] +: 16]};
        end else if (paddr[7:4] == 4'h8 && paddr[1:0] == 2'h0) begin
            rdMux = {16'h0000, injectedResult[16 * paddr[3:2] +: 16]};
        end else begin
            rdHit = 1'b0;
        end
    end

    // apb slave: answer in the first access cycle
    always @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apbSetup;
            if (apbSetup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdMux;
                pslverr <= !rdHit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // configuration writes
    always @(posedge clk) begin
        if (!reset_n) begin
            ctrlOne_q <= `ASC_RST_CTRL_ONE;
            ctrlTwo_q <= `ASC_RST_CTRL_TWO;
            common_q <= `ASC_RST_ZERO;
            smpHi_q <= `ASC_RST_ZERO;
            smpLo_q <= `ASC_RST_ZERO;
            regLen_q <= 4'h0;
            regSlotLo_q <= `ASC_RST_ZERO;
            regSlotHi_q <= `ASC_RST_ZERO;
            injSeq_q <= `ASC_RST_ZERO;
        end else if (apbWrite) begin
            // alignment and repeat/power bits are stored, not acted on
            if (paddr == `ASC_OFF_CTRL_ONE) begin
                ctrlOne_q <= pwdata;
            end else if (paddr == `ASC_OFF_CTRL_TWO) begin
                ctrlTwo_q <= pwdata;
            end else if (paddr == `ASC_OFF_COMMON) begin
                common_q <= pwdata;
            end else if (paddr == `ASC_OFF_SMP_HI) begin
                smpHi_q <= pwdata;
            end else if (paddr == `ASC_OFF_SMP_LO) begin
                smpLo_q <= pwdata;
            end else if (paddr == `ASC_OFF_REG_LEN) begin
                regLen_q <= pwdata[3:0];
            end else if (paddr == `ASC_OFF_REG_SLOT_LO) begin
                regSlotLo_q <= pwdata;
            end else if (paddr == `ASC_OFF_REG_SLOT_HI) begin
                regSlotHi_q <= pwdata;
            end else if (paddr == `ASC_OFF_INJ_SEQ) begin
                injSeq_q <= pwdata;
            end
        end
    end

    // sequencer
    always @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            curInj_q <= 1'b0;
            curCh_q <= 4'h0;
            regIdx_q <= 4'h0;
            injIdx_q <= 2'h0;
            regLeft_q <= 5'h00;
            injLeft_q <= 3'h0;
            autoStart_q <= 1'b0;
        end else begin
            // auto start once the regular group ends
            autoStart_q <= regEnd && autoInj;
            case (state_q)
                ST_IDLE: begin
                    // triggers taken directly; ignored while a burst is pending
                    if (regularTrigger && regLeft_q == 5'h00) begin
                        regLeft_q <= regBurst;
                    end
                    if ((injectedTrigger || autoStart_q) && injLeft_q == 3'h0) begin
                        injLeft_q <= injBurst;
                    end
                    if (startConv) begin
                        state_q <= ST_CONV;
                        curInj_q <= startInj;
                        curCh_q <= nextCh;
                    end
                end
                default: begin
                    if (regularTrigger && regLeft_q == 5'h00 && !timerDone) begin
                        regLeft_q <= regBurst;
                    end
                    if ((injectedTrigger || autoStart_q) && injLeft_q == 3'h0 &&
                        !timerDone) begin
                        injLeft_q <= injBurst;
                    end
                    if (timerDone) begin
                        state_q <= ST_IDLE;
                        // wrap to first element and wait for a trigger
                        if (curInj_q) begin
                            injIdx_q <= injEnd ? 2'h0 : injIdx_q + 2'h1;
                            injLeft_q <= injEnd ? 3'h0 : injLeft_q - 3'h1;
                        end else begin
                            regIdx_q <= regEnd ? 4'h0 : regIdx_q + 4'h1;
                            regLeft_q <= regEnd ? 5'h00 : regLeft_q - 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // flags, pulses and activity
    always @(posedge clk) begin
        if (!reset_n) begin
            doneFlag_q <= 1'b0;
            injFlag_q <= 1'b0;
            donePulseOut <= 1'b0;
            injectedDonePulseOut <= 1'b0;
            converterActive <= 1'b0;
        end else begin
            // set wins over a write-one clear in the same cycle
            if (setDone) begin
                doneFlag_q <= 1'b1;
            end else if (apbWrite && paddr == `ASC_OFF_STATUS &&
                pwdata[`ASC_BIT_DONE_FLAG]) begin
                doneFlag_q <= 1'b0;
            end
            if (setInj) begin
                injFlag_q <= 1'b1;
            end else if (apbWrite && paddr == `ASC_OFF_STATUS &&
                pwdata[`ASC_BIT_INJ_FLAG]) begin
                injFlag_q <= 1'b0;
            end
            // each pulse gated by its enable
            donePulseOut <= setDone && doneIe;
            injectedDonePulseOut <= setInj && injDoneIe;
            converterActive <= startConv || (state_q == ST_CONV && !timerDone);
        end
    end

    genvar k;
    generate
        for (k = 0; k < 16; k = k + 1) begin : regSlot
            always @(posedge clk) begin
                if (!reset_n) begin
                    regularResult[16 * k +: 16] <= 16'h0000;
                // entries beyond the length read as zero
                end else if (k > regLen_q) begin
                    regularResult[16 * k +: 16] <= 16'h0000;
                end else if (timerDone && !curInj_q && regIdx_q == k) begin
                    regularResult[16 * k +: 16] <= convResult;
                end
            end
        end
        // all four injected holdings presented together
        for (k = 0; k < 4; k = k + 1) begin : injSlotRes
            always @(posedge clk) begin
                if (!reset_n) begin
                    injectedResult[16 * k +: 16] <= 16'h0000;
                // entries beyond the injected length read as zero
                end else if (k > injLen) begin
                    injectedResult[16 * k +: 16] <= 16'h0000;
                end else if (timerDone && curInj_q && injIdx_q == k) begin
                    injectedResult[16 * k +: 16] <= convResult;
                end
            end
        end
    endgenerate

endmodule

// ### verif/asc_seq_checker.sv
`timescale 1ns/100ps
module asc_seq_checker (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // triggers and samples
    input wire regularTrigger,
    input wire injectedTrigger,
    input wire [191:0] analogInput,
    // results and events
    input wire [255:0] regularResult,
    input wire [63:0] injectedResult,
    input wire donePulseOut,
    input wire injectedDonePulseOut,
    input wire converterActive
);
    reg [13:0] activeCnt_q;
    reg [3:0] actHist_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // run length of one conversion, for the upper bound
    always @(posedge clk) begin
        if (!reset_n || !converterActive) begin
            activeCnt_q <= 14'h0000;
        end else begin
            activeCnt_q <= activeCnt_q + 14'h0001;
        end
        actHist_q <= reset_n ? {actHist_q[2:0], converterActive} : 4'h0;
    end
    AST_APB_ZERO_WAIT: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
        else $error("pready missing in first access cycle");
    AST_APB_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    AST_APB_ERR_UNMAPPED: assert property (psel && penable && paddr == 8'h28 |-> pslverr)
        else $error("no error on unmapped address");
    AST_APB_ERR_QUIET: assert property (psel && penable && paddr == 8'h00 |-> !pslverr)
        else $error("error on mapped address");
    AST_DONE_ONE: assert property (donePulseOut |=> !donePulseOut)
        else $error("done pulse longer than one cycle");
    AST_INJ_ONE: assert property (injectedDonePulseOut |=> !injectedDonePulseOut)
        else $error("injected pulse longer than one cycle");
    AST_PULSE_AFTER_CONV: assert property ((donePulseOut || injectedDonePulseOut) |-> |actHist_q)
        else $error("end pulse without a conversion");
    AST_TRIG_STARTS: assert property ((!converterActive)[*4] ##0 regularTrigger |-> ##[1:3] converterActive)
        else $error("regular trigger did not start a conversion");
    AST_INJ_TRIG_STARTS: assert property ((!converterActive)[*4] ##0 injectedTrigger |-> ##[1:3] converterActive)
        else $error("injected trigger did not start a conversion");
    AST_CONV_BOUNDED: assert property (activeCnt_q <= 14'h1F00)
        else $error("conversion longer than the longest setting");
endmodule
bind asc_sequencer asc_seq_checker chk (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regularTrigger(regularTrigger),
    .injectedTrigger(injectedTrigger), .analogInput(analogInput),
    .regularResult(regularResult), .injectedResult(injectedResult),
    .donePulseOut(donePulseOut), .injectedDonePulseOut(injectedDonePulseOut),
    .converterActive(converterActive));

// ### verif/asc_analog_src.sv
`timescale 1ns/100ps
module asc_analog_src (
    // sampled levels, no internal channels
    output wire [191:0] analogInput
);
    genvar n;
    generate
        for (n = 0; n < 16; n = n + 1) begin : gen_in
            // input n on its own slice
            assign analogInput[12*n+:12] = 12'h5A3 ^ 12'(n * 273);
        end
    endgenerate
endmodule

// ### verif/adc_sequencer_control_test.sv
`timescale 1ns/100ps
`include "asc_consts.vh"
module adc_sequencer_control_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic regularTrigger = 1'b0;
    logic injectedTrigger = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, donePulseOut, injectedDonePulseOut, converterActive;
    wire [191:0] analogInput;
    wire [255:0] regularResult;
    wire [63:0] injectedResult;
    int n_errors = 0;
    int compares = 0;
    int act0, nAct, nRise, nDone, nInj, i;
    int smpTbl[8] = '{3, 15, 28, 56, 84, 112, 144, 480};
    int lenTbl[4] = '{15, 13, 11, 9};
    int chans[4] = '{5, 0, 15, 9};
    int dCnt[6] = '{1, 1, 2, 2, 7, 7};
    int dLen[6] = '{3, 3, 3, 3, 15, 15};
    int dRise[6] = '{2, 2, 3, 1, 8, 8};
    logic [31:0] rdata;
    logic err;
    always #25 clk = ~clk;
    asc_sequencer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .regularTrigger(regularTrigger), .injectedTrigger(injectedTrigger),
        .analogInput(analogInput), .regularResult(regularResult),
        .injectedResult(injectedResult), .donePulseOut(donePulseOut),
        .injectedDonePulseOut(injectedDonePulseOut), .converterActive(converterActive));
    asc_analog_src src (.analogInput(analogInput));
    function automatic logic [31:0] expRes(input int ch, input int res);
        logic [15:0] v;
        v = {4'h0, 12'h5A3 ^ 12'(ch * 273)};
        return 32'(v >> (2 * res));
    endfunction
    task give_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("apb answer", 32'h1, {31'h0, pready});
        if (pready !== 1'b1)
            give_verdict();
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, e, rdata);
    endtask
    // one trigger, then watch until the block has been quiet for a while
    task conv(input logic inj);
        int k, idle;
        logic prev;
        nAct = 0;
        nRise = 0;
        nDone = 0;
        nInj = 0;
        idle = 0;
        prev = 1'b0;
        if (inj)
            injectedTrigger <= 1'b1;
        else
            regularTrigger <= 1'b1;
        @(posedge clk);
        injectedTrigger <= 1'b0;
        regularTrigger <= 1'b0;
        for (k = 0; k < 20000 && !(nRise > 0 && idle > 8); k++) begin
            @(posedge clk);
            idle = (converterActive === 1'b1) ? 0 : idle + 1;
            nAct += (converterActive === 1'b1);
            nRise += (converterActive === 1'b1 && !prev);
            prev = converterActive;
            nDone += (donePulseOut === 1'b1);
            nInj += (injectedDonePulseOut === 1'b1);
        end
        chk("conv finished", 32'h0, 32'(k >= 20000));
        if (k >= 20000)
            give_verdict();
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdc("ctrl two", `ASC_OFF_CTRL_TWO, `ASC_RST_CTRL_TWO);
        rdc("ctrl one", `ASC_OFF_CTRL_ONE, `ASC_RST_CTRL_ONE);
        rdc("status", `ASC_OFF_STATUS, `ASC_RST_ZERO);
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rdata);
        apb(1'b1, 8'hF0, 32'hFFFF_FFFF);
        chk("unmapped wr err", 32'h1, {31'h0, err});
        wr(`ASC_OFF_CTRL_TWO, 32'h0000_0001);
        wr(`ASC_OFF_CTRL_ONE, 32'h0000_0020);
        conv(1'b0);
        act0 = nAct;
        chk("single rises", 32'h1, 32'(nRise));
        chk("base result", expRes(0, 0), 32'(regularResult[15:0]));
        for (i = 1; i < 8; i++) begin
            wr(`ASC_OFF_COMMON, 32'(i % 4) << 16);
            wr(`ASC_OFF_SMP_LO, 32'(i));
            wr(`ASC_OFF_CTRL_ONE, (32'(i / 2) << 24) | 32'h0000_0020);
            conv(1'b0);
            chk("conv time", 32'((smpTbl[i] + lenTbl[i/2]) * (2 << (i % 4)) - 36), 32'(nAct - act0));
            chk("res result", expRes(0, i / 2), 32'(regularResult[15:0]));
        end
        rdc("ctrl one rb", `ASC_OFF_CTRL_ONE, 32'h0300_0020);
        wr(`ASC_OFF_COMMON, 32'h0000_0000);
        wr(`ASC_OFF_SMP_LO, 32'h0000_0000);
        wr(`ASC_OFF_REG_LEN, 32'h0000_0003);
        wr(`ASC_OFF_REG_SLOT_LO, 32'h0000_9F05);
        wr(`ASC_OFF_CTRL_ONE, 32'h0000_0120);
        conv(1'b0);
        chk("scan rises", 32'h4, 32'(nRise));
        chk("group done", 32'h1, 32'(nDone));
        for (i = 0; i < 16; i++)
            chk("reg slot", (i < 4) ? expRes(chans[i % 4], 0) : 32'h0, 32'(regularResult[16*i+:16]));
        apb(1'b0, `ASC_OFF_STATUS, 32'h0000_0000);
        chk("wrapped index", 32'h0, rdata & 32'h0000_00F0);
        wr(`ASC_OFF_CTRL_TWO, 32'h0000_0401);
        conv(1'b0);
        chk("each done", 32'h4, 32'(nDone));
        wr(`ASC_OFF_CTRL_TWO, 32'h0000_0001);
        for (i = 0; i < 6; i++) begin
            wr(`ASC_OFF_REG_LEN, 32'(dLen[i]));
            wr(`ASC_OFF_CTRL_ONE, 32'h0000_0820 | (32'(dCnt[i]) << 13));
            conv(1'b0);
            chk("disc rises", 32'(dRise[i]), 32'(nRise));
        end
        // pulses off while flags still run
        wr(`ASC_OFF_REG_LEN, 32'h0000_0003);
        wr(`ASC_OFF_CTRL_ONE, 32'h0000_2800);
        for (i = 0; i < 2; i++) begin
            conv(1'b0);
            chk("gated done", 32'h0, 32'(nDone));
        end
        wr(`ASC_OFF_INJ_SEQ, 32'h0010_7200);
        wr(`ASC_OFF_CTRL_ONE, 32'h0000_01A0);
        conv(1'b1);
        chk("inj rises", 32'h2, 32'(nRise));
        chk("inj pulse", 32'h1, 32'(nInj));
        chk("inj done", 32'h1, 32'(nDone));
        chk("inj el0", expRes(2, 0), 32'(injectedResult[15:0]));
        chk("inj el1", expRes(7, 0), 32'(injectedResult[31:16]));
        chk("inj unused", 32'h0, injectedResult[63:32]);
        wr(`ASC_OFF_CTRL_ONE, 32'h0000_11A0);
        for (i = 0; i < 2; i++) begin
            conv(1'b1);
            chk("inj disc rises", 32'h1, 32'(nRise));
            chk("inj disc end", 32'(i), 32'(nInj));
        end
        wr(`ASC_OFF_REG_LEN, 32'h0000_0000);
        wr(`ASC_OFF_CTRL_ONE, 32'h0000_05A0);
        conv(1'b0);
        chk("auto rises", 32'h3, 32'(nRise));
        chk("auto inj end", 32'h1, 32'(nInj));
        rdc("flags set", `ASC_OFF_STATUS, 32'h0000_0003);
        wr(`ASC_OFF_STATUS, 32'h0000_0003);
        rdc("flags clear", `ASC_OFF_STATUS, 32'h0000_0000);
        give_verdict();
    end
endmodule
